// ---- logic/mpw_defines.svh ----
// Register offsets, field positions and reset values of the MAC tail bank.
`ifndef MPW_DEFINES_SVH
`define MPW_DEFINES_SVH
// ============================================================
// Register byte addresses
`define MPW_OFF_SA4_TOP      8'hB4
`define MPW_OFF_TYPE_ID      8'hB8
`define MPW_OFF_TX_PAUSE_Q   8'hBC
`define MPW_OFF_USER_IO      8'hC0
`define MPW_OFF_WAKE_CFG     8'hC4
`define MPW_OFF_NET_CTRL     8'hC8
`define MPW_OFF_NET_CFG      8'hCC
`define MPW_OFF_VERSION      8'hFC
// ============================================================
// Reset values
`define MPW_RST_TX_PAUSE_Q   16'hFFFF
`define MPW_RST_WAKE_CFG     20'h0FFFF
// Arbitrary neutral version value.
`define MPW_VERSION_VALUE    16'h0001
// ============================================================
// User input/output register bits
`define MPW_UIO_RMII         0
`define MPW_UIO_EXT_MATCH    1
`define MPW_UIO_PAUSE_TGL    2
`define MPW_UIO_ZERO_Q       3
`define MPW_UIO_LOOPBACK     16
`define MPW_UIO_HALF_DUPLEX  17
`define MPW_UIO_BITRATE      18
`define MPW_UIO_SPEED        19
`define MPW_UIO_WAKE         20
// ============================================================
// Wake configuration enables
`define MPW_WK_MAGIC         16
`define MPW_WK_ARP           17
`define MPW_WK_FIRST_ADDR    18
`define MPW_WK_HASH          19
// ============================================================
// Own network control and configuration bits
`define MPW_NCTL_LOOPBACK    0
`define MPW_NCFG_SPEED       0
`define MPW_NCFG_FULL_DUPLEX 1
`define MPW_NCFG_BITRATE     2
`define MPW_NCFG_EXT_ADDR_EN 3
// AXI response codes
`define MPW_RESP_OKAY        2'h0
`define MPW_RESP_SLVERR      2'h2
`endif

// ---- logic/mpw_pkg.sv ----
// Types for the MAC pause and wake configuration bank.
`default_nettype none
package mpw_pkg;
  typedef enum logic [0:0] {
    MPW_WR_IDLE,
    MPW_WR_RESP
  } mpw_wr_state_t;

  typedef struct packed {
    mpw_wr_state_t wr_state;
    logic          aw_held;
    logic [7:0]    aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [15:0]   sa4_top;
    logic [15:0]   type_id;
    logic [15:0]   pause_q;
    logic          rmii;
    logic          zero_q;
    logic          pause_tgl;
    logic          pause_tgl_seen;
    logic          wake_det;
    logic [19:0]   wake_cfg;
    logic          net_loopback;
    logic [3:0]    net_cfg;
    logic          pause_req;
    logic [15:0]   pause_value;
    logic          frame_copy;
    logic          type_hit;
    logic          wake_out;
  } mpw_state_t;
endpackage
`default_nettype wire

// ---- logic/mpw_regs.sv ----
// Tail register bank of a 10/100 MAC: pause, wake and user I/O control.
`timescale 1ns/1ns
`default_nettype none
`include "mpw_defines.svh"
// Summary of operation
// - Hold address bits 32-47 in low half.
// - Compare programmed value to frame type field.
// - Pause frames carry quantum, reset all ones.
// - Zero-quantum bit forces zero pause length.
// - Each toggle of pause bit sends frame.
// - External match plus enable copies frame.
// - Interface bit: zero MII, one RMII.
// - Wake status shows detection, never software-set.
// - Half-duplex reads inverse of full-duplex bit.
// - Speed, bitrate, loopback mirror configuration bits.
// - Wake status bit clears on write one.
// - Four enables gate wake event sources.
// - ARP target IP low half match wakes.
// - Zero programmed IP never wakes.
// - Read-only version in low 16 bits.
// - System and peripheral clocks share one here.
module mpw_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_frame_end,
  input  wire logic [15:0] rx_type_len,
  input  wire logic        ext_addr_match_in,
  input  wire logic        rx_hash_hit,
  input  wire logic        rx_first_addr_hit,
  input  wire logic        rx_arp_request,
  input  wire logic [15:0] rx_arp_target_ip,
  input  wire logic        rx_magic_packet,
  output logic             rmii_mode,
  output logic             pause_send,
  output logic [15:0]      pause_quantum,
  output logic             frame_copy,
  output logic             type_id_hit,
  output logic [15:0]      specific_addr4_top,
  output logic             wake_on_lan,
  output logic             loopback_en,
  output logic             full_duplex_cfg,
  output logic             speed_100,
  output logic             bitrate_sel
);
  // ============================================================
  // State
  mpw_pkg::mpw_state_t st_reg;
  mpw_pkg::mpw_state_t st_next;

  function automatic logic [31:0] read_word(
    input mpw_pkg::mpw_state_t s,
    input logic [7:0]          a
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `MPW_OFF_SA4_TOP:    v[15:0] = s.sa4_top;
      `MPW_OFF_TYPE_ID:    v[15:0] = s.type_id;
      `MPW_OFF_TX_PAUSE_Q: v[15:0] = s.pause_q;
      `MPW_OFF_USER_IO: begin
        v[`MPW_UIO_RMII]        = s.rmii;
        v[`MPW_UIO_EXT_MATCH]   = ext_addr_match_in;
        v[`MPW_UIO_PAUSE_TGL]   = s.pause_tgl;
        v[`MPW_UIO_ZERO_Q]      = s.zero_q;
        v[`MPW_UIO_LOOPBACK]    = s.net_loopback;
        v[`MPW_UIO_HALF_DUPLEX] = ~s.net_cfg[`MPW_NCFG_FULL_DUPLEX];
        v[`MPW_UIO_BITRATE]     = s.net_cfg[`MPW_NCFG_BITRATE];
        v[`MPW_UIO_SPEED]       = s.net_cfg[`MPW_NCFG_SPEED];
        v[`MPW_UIO_WAKE]        = s.wake_det;
      end
      `MPW_OFF_WAKE_CFG:   v[19:0] = s.wake_cfg;
      `MPW_OFF_NET_CTRL:   v[`MPW_NCTL_LOOPBACK] = s.net_loopback;
      `MPW_OFF_NET_CFG:    v[3:0] = s.net_cfg;
      `MPW_OFF_VERSION:    v[15:0] = `MPW_VERSION_VALUE;
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `MPW_OFF_SA4_TOP, `MPW_OFF_TYPE_ID, `MPW_OFF_TX_PAUSE_Q,
      `MPW_OFF_USER_IO, `MPW_OFF_WAKE_CFG, `MPW_OFF_NET_CTRL,
      `MPW_OFF_NET_CFG, `MPW_OFF_VERSION: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Byte-lane merge of a write into a 32-bit old value.
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  logic        wr_fire;
  logic [31:0] wr_word;
  logic        wake_event;
  logic        aw_rdy_reg;
  logic        w_rdy_reg;
  logic        ar_rdy_reg;

  // ============================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    wr_fire = 1'b0;
    wr_word = 32'h0000_0000;
    // A clean event pulses for one cycle; the pin is registered below.
    wake_event = (rx_magic_packet & st_reg.wake_cfg[`MPW_WK_MAGIC])
      | (rx_hash_hit & st_reg.wake_cfg[`MPW_WK_HASH])
      | (rx_first_addr_hit & st_reg.wake_cfg[`MPW_WK_FIRST_ADDR])
      | (rx_arp_request & st_reg.wake_cfg[`MPW_WK_ARP]
         & (st_reg.wake_cfg[15:0] != 16'h0000)
         & (rx_arp_target_ip == st_reg.wake_cfg[15:0]));

    if (s_axi_awvalid && aw_rdy_reg) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && w_rdy_reg) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    case (st_reg.wr_state)
      mpw_pkg::MPW_WR_IDLE: begin
        if (st_reg.aw_held && st_reg.w_held) begin
          wr_fire = 1'b1;
          st_next.aw_held = 1'b0;
          st_next.w_held = 1'b0;
          st_next.bvalid = 1'b1;
          st_next.bresp = addr_ok(st_reg.aw_addr) ? `MPW_RESP_OKAY
                                                  : `MPW_RESP_SLVERR;
          st_next.wr_state = mpw_pkg::MPW_WR_RESP;
        end
      end
      mpw_pkg::MPW_WR_RESP: begin
        if (s_axi_bready) begin
          st_next.bvalid = 1'b0;
          st_next.wr_state = mpw_pkg::MPW_WR_IDLE;
        end
      end
      default: st_next.wr_state = mpw_pkg::MPW_WR_IDLE;
    endcase

    if (wr_fire) begin
      wr_word = merge(read_word(st_reg, st_reg.aw_addr),
                      st_reg.w_data, st_reg.w_strb);
      case (st_reg.aw_addr)
        `MPW_OFF_SA4_TOP:    st_next.sa4_top = wr_word[15:0];
        `MPW_OFF_TYPE_ID:    st_next.type_id = wr_word[15:0];
        `MPW_OFF_TX_PAUSE_Q: st_next.pause_q = wr_word[15:0];
        `MPW_OFF_USER_IO: begin
          st_next.rmii      = wr_word[`MPW_UIO_RMII];
          st_next.zero_q    = wr_word[`MPW_UIO_ZERO_Q];
          st_next.pause_tgl = wr_word[`MPW_UIO_PAUSE_TGL];
          if (st_reg.w_strb[2] && st_reg.w_data[`MPW_UIO_WAKE]) begin
            st_next.wake_det = 1'b0;
          end
        end
        `MPW_OFF_WAKE_CFG:   st_next.wake_cfg = wr_word[19:0];
        `MPW_OFF_NET_CTRL:
          st_next.net_loopback = wr_word[`MPW_NCTL_LOOPBACK];
        `MPW_OFF_NET_CFG:    st_next.net_cfg = wr_word[3:0];
        default: st_next.sa4_top = st_reg.sa4_top;
      endcase
    end
    // A wake event in the clearing cycle wins over the clear.
    if (wake_event) begin
      st_next.wake_det = 1'b1;
    end
    st_next.wake_out = wake_event;

    // Pause frame request on each change of the toggle bit.
    st_next.pause_tgl_seen = st_reg.pause_tgl;
    st_next.pause_req = st_reg.pause_tgl ^ st_reg.pause_tgl_seen;
    st_next.pause_value = st_reg.zero_q ? 16'h0000 : st_reg.pause_q;

    st_next.frame_copy = ext_addr_match_in
                       & st_reg.net_cfg[`MPW_NCFG_EXT_ADDR_EN];
    st_next.type_hit = rx_frame_end
                     & (rx_type_len == st_reg.type_id);

    if (st_reg.rvalid) begin
      if (s_axi_rready) begin
        st_next.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid && ar_rdy_reg) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = read_word(st_reg, {s_axi_araddr[7:2], 2'b00});
      st_next.rresp = addr_ok({s_axi_araddr[7:2], 2'b00}) ? `MPW_RESP_OKAY
                                                         : `MPW_RESP_SLVERR;
    end

    // Ready is offered only while the matching holding slot is empty.
    if (rst) begin
      st_next = '0;
      st_next.wr_state = mpw_pkg::MPW_WR_IDLE;
      st_next.pause_q = `MPW_RST_TX_PAUSE_Q;
      st_next.wake_cfg = `MPW_RST_WAKE_CFG;
      st_next.pause_value = `MPW_RST_TX_PAUSE_Q;
    end
  end

  // ============================================================
  // Registers; one clock serves both bus sides in this build.
  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  // ============================================================
  // Outputs, all from flip-flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_rdy_reg <= 1'b0;
      w_rdy_reg <= 1'b0;
      ar_rdy_reg <= 1'b0;
    end else begin
      // Ready stands only while its slot is empty, so a handshake can
      // never overwrite a word that is still waiting.
      aw_rdy_reg <= !st_next.aw_held;
      w_rdy_reg <= !st_next.w_held;
      ar_rdy_reg <= !st_next.rvalid;
    end
  end
  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign rmii_mode = st_reg.rmii;
  assign pause_send = st_reg.pause_req;
  assign pause_quantum = st_reg.pause_value;
  assign frame_copy = st_reg.frame_copy;
  assign type_id_hit = st_reg.type_hit;
  // Bit zero holds address bit 32, the low bit of the fifth address byte.
  assign specific_addr4_top = st_reg.sa4_top;
  assign wake_on_lan = st_reg.wake_out;
  assign loopback_en = st_reg.net_loopback;
  assign full_duplex_cfg = st_reg.net_cfg[`MPW_NCFG_FULL_DUPLEX];
  assign speed_100 = st_reg.net_cfg[`MPW_NCFG_SPEED];
  assign bitrate_sel = st_reg.net_cfg[`MPW_NCFG_BITRATE];
endmodule
`default_nettype wire

// ---- sim/mpw_regs_properties.sv ----
// Port-level assertions for the MAC pause and wake register bank.
`timescale 1ns/1ns
`default_nettype none
module mpw_regs_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_frame_end,
  input wire logic        ext_addr_match_in,
  input wire logic        rx_hash_hit,
  input wire logic        rx_first_addr_hit,
  input wire logic        rx_arp_request,
  input wire logic [15:0] rx_arp_target_ip,
  input wire logic        rx_magic_packet,
  input wire logic        pause_send,
  input wire logic [15:0] pause_quantum,
  input wire logic        frame_copy,
  input wire logic        type_id_hit,
  input wire logic        wake_on_lan
);
  // ==========================================================
  // Clocking and helpers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic any_evt;
  assign any_evt = rx_hash_hit | rx_first_addr_hit | rx_arp_request |
                   rx_magic_packet;
  // ==========================================================
  // Assertions
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rresp_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  a_copy_cause: assert property (
    frame_copy |-> $past(ext_addr_match_in)) else $error("copy without match");
  a_type_cause: assert property (
    type_id_hit |-> $past(rx_frame_end)) else $error("type hit without frame");
  a_wake_cause: assert property (
    wake_on_lan |-> $past(any_evt)) else $error("wake without event");
  a_arp_zero: assert property (
    rx_arp_request && rx_arp_target_ip == 16'h0000 && !rx_hash_hit &&
    !rx_first_addr_hit && !rx_magic_packet |=> !wake_on_lan)
    else $error("wake on zero address");
  a_pause_single: assert property (
    pause_send |=> !pause_send) else $error("pause pulse too long");
  a_reset_values: assert property (
    $fell(rst) |-> pause_quantum == 16'hFFFF && !pause_send && !wake_on_lan)
    else $error("wrong values after reset");
  c_pause: cover property (pause_send);
  c_wake: cover property (wake_on_lan);
  c_copy: cover property (frame_copy);
endmodule
bind mpw_regs mpw_regs_properties u_props (.clk_sys, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .rx_frame_end, .ext_addr_match_in, .rx_hash_hit, .rx_first_addr_hit,
  .rx_arp_request, .rx_arp_target_ip, .rx_magic_packet, .pause_send,
  .pause_quantum, .frame_copy, .type_id_hit, .wake_on_lan);
`default_nettype wire

// ---- sim/mpw_phy_model.sv ----
// Behavioural receive side that feeds frame and wake events to the bank.
`timescale 1ns/1ns
`default_nettype none
module mpw_phy_model (
  input  wire logic        clk_sys,
  output logic             rx_frame_end,
  output logic [15:0]      rx_type_len,
  output logic             ext_addr_match_in,
  output logic             rx_hash_hit,
  output logic             rx_first_addr_hit,
  output logic             rx_arp_request,
  output logic [15:0]      rx_arp_target_ip,
  output logic             rx_magic_packet
);
  logic [3:0] ev;
  assign {rx_hash_hit, rx_first_addr_hit, rx_arp_request, rx_magic_packet} = ev;
  initial begin
    ev = 4'h0;
    rx_frame_end = 1'b0;
    rx_type_len = 16'h0000;
    rx_arp_target_ip = 16'h0000;
    ext_addr_match_in = 1'b0;
  end
  // Fields are only valid with their pulse; afterwards they show the
  // inverse so that a stale value is never mistaken for a fresh one.
  task automatic pulse(input logic [3:0] e, input logic f,
                       input logic [15:0] v);
    @(posedge clk_sys);
    ev <= e;
    rx_frame_end <= f;
    rx_type_len <= v;
    rx_arp_target_ip <= v;
    @(posedge clk_sys);
    ev <= 4'h0;
    rx_frame_end <= 1'b0;
    rx_type_len <= ~v;
    rx_arp_target_ip <= ~v;
  endtask
  task automatic set_match(input logic b);
    @(posedge clk_sys);
    ext_addr_match_in <= b;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_mpw_regs.sv ----
// Self-checking bench for the MAC pause and wake register bank.
`timescale 1ns/1ns
`default_nettype none
`include "mpw_defines.svh"
module tb_mpw_regs;
  localparam logic [1:0] ok = `MPW_RESP_OKAY;
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rx_frame_end;
  logic        ext_addr_match_in, rx_hash_hit, rx_first_addr_hit;
  logic        rx_arp_request, rx_magic_packet, rmii_mode, pause_send;
  logic [15:0] rx_type_len, rx_arp_target_ip, pause_quantum;
  logic [15:0] specific_addr4_top;
  logic        frame_copy, type_id_hit, wake_on_lan, loopback_en;
  logic        full_duplex_cfg, speed_100, bitrate_sel;
  int          error_cnt = 0, checks = 0, pause_cnt = 0, hit_cnt = 0;
  int          wake_cnt = 0;
  mpw_regs dut (.*);
  mpw_phy_model phy (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (pause_send === 1'b1) pause_cnt++;
    if (type_id_hit === 1'b1) hit_cnt++;
    if (wake_on_lan === 1'b1) wake_cnt++;
  end
  // ==========================================================
  // Shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(n);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    logic ad, dn;
    ad = 1'b0;
    dn = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20 && !(ad && dn); n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid && !dn) begin
        dn = 1'b1;
        rdv = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    tmo(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, ok);
    chk(rdv, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdc(`MPW_OFF_SA4_TOP, 32'h0);
    rdc(`MPW_OFF_TX_PAUSE_Q, 32'h0000FFFF);
    rdc(`MPW_OFF_WAKE_CFG, 32'h0000FFFF);
    rdc(`MPW_OFF_VERSION, {16'h0, `MPW_VERSION_VALUE});
    rdc(`MPW_OFF_USER_IO, 32'h00020000);
    rd(8'h10, `MPW_RESP_SLVERR);
    chk(rdv, 32'h0);
    wr(8'h10, 32'hFFFFFFFF, `MPW_RESP_SLVERR);
  endtask
  task automatic t_store;
    wr(`MPW_OFF_SA4_TOP, 32'hA5A55A5A, ok);
    wr(`MPW_OFF_TYPE_ID, 32'hA5A55A5A, ok);
    wr(`MPW_OFF_WAKE_CFG, 32'hFFFFFFFF, ok);
    rdc(`MPW_OFF_SA4_TOP, 32'h00005A5A);
    rdc(`MPW_OFF_TYPE_ID, 32'h00005A5A);
    rdc(`MPW_OFF_WAKE_CFG, 32'h000FFFFF);
    chk({16'h0, specific_addr4_top}, 32'h00005A5A);
    s_axi_wstrb <= 4'h2;
    wr(`MPW_OFF_SA4_TOP, 32'h0000C300, ok);
    s_axi_wstrb <= 4'hF;
    rdc(`MPW_OFF_SA4_TOP, 32'h0000C35A);
  endtask
  task automatic t_mirror;
    wr(`MPW_OFF_NET_CTRL, 32'h1, ok);
    wr(`MPW_OFF_NET_CFG, 32'h7, ok);
    rdc(`MPW_OFF_USER_IO, 32'h000D0000);
    wr(`MPW_OFF_USER_IO, 32'h000F0001, ok);
    rdc(`MPW_OFF_USER_IO, 32'h000D0001);
    chk({27'h0, rmii_mode, loopback_en, full_duplex_cfg, speed_100,
         bitrate_sel}, 32'h1F);
    wr(`MPW_OFF_NET_CFG, 32'h0, ok);
    wr(`MPW_OFF_NET_CTRL, 32'h0, ok);
    wr(`MPW_OFF_USER_IO, 32'h0, ok);
    rdc(`MPW_OFF_USER_IO, 32'h00020000);
  endtask
  task automatic t_pause;
    wr(`MPW_OFF_TX_PAUSE_Q, 32'h1234, ok);
    pause_cnt = 0;
    wr(`MPW_OFF_USER_IO, 32'h4, ok);
    wr(`MPW_OFF_USER_IO, 32'h4, ok);
    idle(2);
    chk(32'(pause_cnt), 32'h1);
    chk({16'h0, pause_quantum}, 32'h1234);
    wr(`MPW_OFF_USER_IO, 32'h8, ok);
    idle(2);
    chk(32'(pause_cnt), 32'h2);
    chk({16'h0, pause_quantum}, 32'h0);
    wr(`MPW_OFF_USER_IO, 32'h0, ok);
    idle(2);
    chk({16'h0, pause_quantum}, 32'h1234);
  endtask
  task automatic t_frames;
    wr(`MPW_OFF_NET_CFG, 32'h8, ok);
    phy.set_match(1'b1);
    idle(2);
    chk({31'h0, frame_copy}, 32'h1);
    rdc(`MPW_OFF_USER_IO, 32'h00020002);
    wr(`MPW_OFF_NET_CFG, 32'h0, ok);
    idle(2);
    chk({31'h0, frame_copy}, 32'h0);
    phy.set_match(1'b0);
    wr(`MPW_OFF_TYPE_ID, 32'h0800, ok);
    hit_cnt = 0;
    phy.pulse(4'h0, 1'b1, 16'h0800);
    phy.pulse(4'h0, 1'b1, 16'h86DD);
    idle(2);
    chk(32'(hit_cnt), 32'h1);
  endtask
  task automatic t_wake;
    for (int k = 0; k < 4; k++) begin
      wr(`MPW_OFF_WAKE_CFG, (32'h1 << (16 + k)) | 32'hAB, ok);
      wake_cnt = 0;
      for (int j = 0; j < 4; j++) phy.pulse(4'h1 << j, 1'b0, 16'h00AB);
      idle(2);
      chk(32'(wake_cnt), 32'h1);
    end
    wr(`MPW_OFF_WAKE_CFG, 32'h000200AB, ok);
    wake_cnt = 0;
    phy.pulse(4'h2, 1'b0, 16'h00AC);
    wr(`MPW_OFF_WAKE_CFG, 32'h00020000, ok);
    phy.pulse(4'h2, 1'b0, 16'h0000);
    idle(2);
    chk(32'(wake_cnt), 32'h0);
    rdc(`MPW_OFF_USER_IO, 32'h00120000);
    wr(`MPW_OFF_USER_IO, 32'h00100000, ok);
    rdc(`MPW_OFF_USER_IO, 32'h00020000);
    wr(`MPW_OFF_USER_IO, 32'h00100000, ok);
    rdc(`MPW_OFF_USER_IO, 32'h00020000);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_store();
    t_mirror();
    t_pause();
    t_frames();
    t_wake();
    end_of_test();
  end
endmodule
`default_nettype wire
